// ===== rsc_pkg.sv
// Purpose: Shared constants and types of the regulator set-point control block
// Assumes: 20 MHz core clock, 7-bit addressing on the serial control port
// Notes: Set-point codes are 5-bit reference codes in the low bits of each byte
package rsc_pkg;
  // Serial slave address, 8-bit write form 0x68
  localparam logic [6:0] I2C_ADDR7 = 7'h34;
  // Command register offsets
  localparam logic [7:0] REG_OUT_EN = 8'h10;
  localparam logic [7:0] REG_SPARE = 8'h14;
  localparam logic [7:0] REG_VCHG = 8'h20;
  // First set-point offset per dynamic rail; second set point sits one above
  localparam logic [3:0][7:0] SP_V1_ADDR = {8'h32, 8'h29, 8'h26, 8'h23};
  // Reset values
  localparam logic [7:0] SP_RESET = 8'h19;
  localparam logic [4:0] CODE_RESET = 5'h19;
  localparam logic [7:0] OUT_EN_RESET = 8'h00;
  localparam logic [7:0] VCHG_RESET = 8'h00;
  localparam logic [7:0] SPARE_RESET = 8'h00;
  // Field widths, positions and counts
  localparam int CODE_W = 5;
  localparam int KA_BIT = 7;
  localparam int N_DYN = 4;
  localparam int N_RAIL = 6;
  // Timing
  localparam int CLK_KHZ = 20000;
  localparam int CLK_NS = 50;
  localparam int RST_MIN_MS = 10;
  localparam int RST_PB_MS = 1000;
  localparam int RST_MIN_CYC = RST_MIN_MS * CLK_KHZ;
  localparam int RST_PB_CYC = RST_PB_MS * CLK_KHZ;
  localparam int SLEW_STEP_NS = 1000;
  localparam int SLEW_STEP_CYC = (SLEW_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_CNT_W = 25;
  localparam int STEP_CNT_W = 8;

  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_ACK_A = 9'h004,
    ST_CMD   = 9'h008,
    ST_ACK_C = 9'h010,
    ST_WDATA = 9'h020,
    ST_ACK_W = 9'h040,
    ST_RDATA = 9'h080,
    ST_RACK  = 9'h100
  } rsc_i2c_st_t;

  // Returns {hit, bank index}; index is {rail, second set point}
  function automatic logic [3:0] sp_decode(input logic [7:0] a);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < N_DYN; i++) begin
      if (a == SP_V1_ADDR[i]) begin
        r = {1'b1, 2'(i), 1'b0};
      end
      if (a == SP_V1_ADDR[i] + 8'h01) begin
        r = {1'b1, 2'(i), 1'b1};
      end
    end
    return r;
  endfunction
endpackage

// ===== rsc_bank_if.sv
// Purpose: Link between the control logic and the set-point bank
// Assumes: One clock domain
// Notes: Targets and keep-alive flags are continuous views of the bank
`timescale 1ns/1ps
interface rsc_bank_if;
  logic we;
  logic [2:0] wr_idx;
  logic [7:0] wr_data;
  logic [2:0] rd_idx;
  logic [7:0] rd_data;
  logic [3:0] stby_sel;
  logic [3:0][4:0] target;
  logic [3:0] keep_alive;
  modport bank (input we, wr_idx, wr_data, rd_idx, stby_sel, output rd_data, target, keep_alive);
  modport ctrl (output we, wr_idx, wr_data, rd_idx, stby_sel, input rd_data, target, keep_alive);
endinterface

// ===== rsc_setpoint_bank.sv
// Purpose: Storage of run and standby set points for the four dynamic rails
// Assumes: Synchronous active-high reset
// Notes: Read data is registered, one cycle after the index
`timescale 1ns/1ps
module rsc_setpoint_bank (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Control side
  rsc_bank_if.bank bus
);
  typedef struct packed {
    logic [7:0][7:0] mem;
    logic [7:0] rd;
  } rsc_bank_st_t;

  rsc_bank_st_t bank_reg;
  rsc_bank_st_t bank_next;

  always_comb begin
    bank_next = bank_reg;
    bank_next.rd = bank_reg.mem[bus.rd_idx];
    if (bus.we) begin
      bank_next.mem[bus.wr_idx] = bus.wr_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      bank_reg.mem <= {8{rsc_pkg::SP_RESET}};
      bank_reg.rd <= 8'h00;
    end else begin
      bank_reg <= bank_next;
    end
  end

  assign bus.rd_data = bank_reg.rd;

  genvar g;
  generate
    for (g = 0; g < rsc_pkg::N_DYN; g++) begin : g_rail
      assign bus.target[g] = bus.stby_sel[g] ? bank_reg.mem[2 * g + 1][4:0] : bank_reg.mem[2 * g][4:0];
      assign bus.keep_alive[g] = bank_reg.mem[2 * g + 1][rsc_pkg::KA_BIT];
    end
  endgenerate
endmodule

// ===== rsc_regulator_ctrl.sv
// Purpose: Serial control, enables, set-point slewing and reset release of a multi-rail power manager
// Assumes: 20 MHz clock; all pins except i_sys_rst asynchronous and synchronised here
// Notes: Set points move only on a go bit or a standby pin change
`timescale 1ns/1ps
module rsc_regulator_ctrl #(
  parameter int P_RST_MIN_CYC = rsc_pkg::RST_MIN_CYC,
  parameter int P_RST_PB_CYC = rsc_pkg::RST_PB_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Serial control port
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  // Processor control pins
  input wire logic i_standby_select_pin,
  input wire logic [3:0] i_step_en_pins,
  input wire logic [1:0] i_linear_enable_pins,
  input wire logic i_hibernate,
  // Reset sources
  input wire logic i_always_on_rail,
  input wire logic i_pb_hard_reset,
  // Outputs
  output logic o_reset_out_n,
  output logic [5:0] o_rail_en,
  output logic [19:0] o_dac_code
);
  typedef struct packed {
    logic scl_s1, scl_s2, scl_q;
    logic sda_s1, sda_s2, sda_q;
    logic stby_s1, stby_s2, stby_q;
    logic aon_s1, aon_s2;
    logic pb_s1, pb_s2;
    logic hib_s1, hib_s2;
    logic [5:0] en_s1, en_s2;
    rsc_pkg::rsc_i2c_st_t state;
    logic [2:0] cnt;
    logic done;
    logic [7:0] shreg;
    logic rw;
    logic [7:0] ptr;
    logic [7:0] rd_byte;
    logic sda_oe;
    logic we;
    logic [2:0] wr_idx;
    logic [7:0] wr_data;
    logic [7:0] output_enable_reg;
    logic [3:0] sel;
    logic [7:0] spare;
    logic [3:0] active;
    logic [3:0][4:0] dac;
    logic [7:0] step_cnt;
    logic [24:0] rst_cnt;
    logic rst_long;
    logic rst_n;
    logic [5:0] rail_en;
  } rsc_ctrl_st_t;

  rsc_ctrl_st_t ctrl_reg;
  rsc_ctrl_st_t ctrl_next;
  rsc_bank_if bank_bus ();
  logic scl_rise, scl_fall, bus_start, bus_stop, tick;
  logic [3:0] rd_hit;
  logic [3:0] wr_hit;
  logic [7:0] rd_val;
  logic [7:0] vchg_view;
  logic [5:0] ka_rail;
  logic [5:0] want_en;

  rsc_setpoint_bank u_bank (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .bus(bank_bus)
  );

  assign scl_rise = ctrl_reg.scl_s2 & ~ctrl_reg.scl_q;
  assign scl_fall = ~ctrl_reg.scl_s2 & ctrl_reg.scl_q;
  assign bus_start = ctrl_reg.scl_s2 & ctrl_reg.scl_q & ctrl_reg.sda_q & ~ctrl_reg.sda_s2;
  assign bus_stop = ctrl_reg.scl_s2 & ctrl_reg.scl_q & ~ctrl_reg.sda_q & ctrl_reg.sda_s2;
  assign tick = (ctrl_reg.step_cnt == 8'(rsc_pkg::SLEW_STEP_CYC - 1));
  assign rd_hit = rsc_pkg::sp_decode(ctrl_reg.ptr);
  assign wr_hit = rsc_pkg::sp_decode(ctrl_reg.ptr);

  assign bank_bus.we = ctrl_reg.we;
  assign bank_bus.wr_idx = ctrl_reg.wr_idx;
  assign bank_bus.wr_data = ctrl_reg.wr_data;
  assign bank_bus.rd_idx = rd_hit[2:0];
  assign bank_bus.stby_sel = {4{ctrl_reg.stby_q}} | ctrl_reg.sel;
  assign ka_rail = {1'b0, bank_bus.keep_alive[3], 1'b0, bank_bus.keep_alive[2:0]};
  assign want_en = ctrl_reg.output_enable_reg[5:0] | ctrl_reg.en_s2;

  // Go bits read back as busy while slewing
  always_comb begin
    vchg_view = 8'h00;
    for (int i = 0; i < rsc_pkg::N_DYN; i++) begin
      vchg_view[2 * i] = ctrl_reg.active[i];
      vchg_view[2 * i + 1] = ctrl_reg.sel[i];
    end
  end

  always_comb begin
    if (rd_hit[3]) begin
      rd_val = bank_bus.rd_data;
    end else if (ctrl_reg.ptr == rsc_pkg::REG_OUT_EN) begin
      rd_val = ctrl_reg.output_enable_reg;
    end else if (ctrl_reg.ptr == rsc_pkg::REG_VCHG) begin
      rd_val = vchg_view;
    end else if (ctrl_reg.ptr == rsc_pkg::REG_SPARE) begin
      rd_val = ctrl_reg.spare;
    end else begin
      rd_val = 8'h00;
    end
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    ctrl_next.we = 1'b0;
    ctrl_next.scl_s1 = i_scl;
    ctrl_next.scl_s2 = ctrl_reg.scl_s1;
    ctrl_next.scl_q = ctrl_reg.scl_s2;
    ctrl_next.sda_s1 = i_sda;
    ctrl_next.sda_s2 = ctrl_reg.sda_s1;
    ctrl_next.sda_q = ctrl_reg.sda_s2;
    ctrl_next.stby_s1 = i_standby_select_pin;
    ctrl_next.stby_s2 = ctrl_reg.stby_s1;
    ctrl_next.stby_q = ctrl_reg.stby_s2;
    ctrl_next.aon_s1 = i_always_on_rail;
    ctrl_next.aon_s2 = ctrl_reg.aon_s1;
    ctrl_next.pb_s1 = i_pb_hard_reset;
    ctrl_next.pb_s2 = ctrl_reg.pb_s1;
    ctrl_next.hib_s1 = i_hibernate;
    ctrl_next.hib_s2 = ctrl_reg.hib_s1;
    ctrl_next.en_s1 = {i_linear_enable_pins, i_step_en_pins};
    ctrl_next.en_s2 = ctrl_reg.en_s1;

    ctrl_next.step_cnt = tick ? 8'h00 : ctrl_reg.step_cnt + 8'h01;
    for (int i = 0; i < rsc_pkg::N_DYN; i++) begin
      if (ctrl_reg.active[i]) begin
        if (ctrl_reg.dac[i] == bank_bus.target[i]) begin
          ctrl_next.active[i] = 1'b0;
        end else if (tick) begin
          if (ctrl_reg.dac[i] < bank_bus.target[i]) begin
            ctrl_next.dac[i] = ctrl_reg.dac[i] + 5'h01;
          end else begin
            ctrl_next.dac[i] = ctrl_reg.dac[i] - 5'h01;
          end
        end
      end
    end
    if (ctrl_reg.stby_s2 != ctrl_reg.stby_q) begin
      ctrl_next.active = 4'hF;
    end

    if (bus_start) begin
      ctrl_next.state = rsc_pkg::ST_ADDR;
      ctrl_next.cnt = 3'h0;
      ctrl_next.done = 1'b0;
      ctrl_next.sda_oe = 1'b0;
    end else if (bus_stop) begin
      ctrl_next.state = rsc_pkg::ST_IDLE;
      ctrl_next.sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (ctrl_reg.state)
        rsc_pkg::ST_ADDR, rsc_pkg::ST_CMD, rsc_pkg::ST_WDATA: begin
          ctrl_next.shreg = {ctrl_reg.shreg[6:0], ctrl_reg.sda_s2};
          ctrl_next.cnt = ctrl_reg.cnt + 3'h1;
          ctrl_next.done = (ctrl_reg.cnt == 3'h7);
        end
        rsc_pkg::ST_RACK: begin
          ctrl_next.state = ctrl_reg.sda_s2 ? rsc_pkg::ST_IDLE : rsc_pkg::ST_ACK_A;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (ctrl_reg.state)
        rsc_pkg::ST_ADDR: begin
          if (ctrl_reg.done) begin
            ctrl_next.done = 1'b0;
            if (ctrl_reg.shreg[7:1] == rsc_pkg::I2C_ADDR7) begin
              ctrl_next.rw = ctrl_reg.shreg[0];
              ctrl_next.sda_oe = 1'b1;
              ctrl_next.state = rsc_pkg::ST_ACK_A;
            end else begin
              ctrl_next.state = rsc_pkg::ST_IDLE;
            end
          end
        end
        rsc_pkg::ST_CMD: begin
          if (ctrl_reg.done) begin
            ctrl_next.done = 1'b0;
            ctrl_next.ptr = ctrl_reg.shreg;
            ctrl_next.sda_oe = 1'b1;
            ctrl_next.state = rsc_pkg::ST_ACK_C;
          end
        end
        rsc_pkg::ST_WDATA: begin
          if (ctrl_reg.done) begin
            ctrl_next.done = 1'b0;
            ctrl_next.sda_oe = 1'b1;
            ctrl_next.state = rsc_pkg::ST_ACK_W;
            if (ctrl_reg.ptr == rsc_pkg::REG_OUT_EN) begin
              ctrl_next.output_enable_reg = ctrl_reg.shreg;
            end
            if (ctrl_reg.ptr == rsc_pkg::REG_VCHG) begin
              for (int i = 0; i < rsc_pkg::N_DYN; i++) begin
                ctrl_next.sel[i] = ctrl_reg.shreg[2 * i + 1];
                if (ctrl_reg.shreg[2 * i]) begin
                  ctrl_next.active[i] = 1'b1;
                end
              end
            end
            if (ctrl_reg.ptr == rsc_pkg::REG_SPARE) begin
              ctrl_next.spare = ctrl_reg.shreg;
            end
            if (wr_hit[3]) begin
              ctrl_next.we = 1'b1;
              ctrl_next.wr_idx = wr_hit[2:0];
              ctrl_next.wr_data = ctrl_reg.shreg;
            end
          end
        end
        rsc_pkg::ST_ACK_A: begin
          if (ctrl_reg.rw) begin
            ctrl_next.rd_byte = rd_val;
            ctrl_next.sda_oe = ~rd_val[7];
            ctrl_next.cnt = 3'h1;
            ctrl_next.state = rsc_pkg::ST_RDATA;
          end else begin
            ctrl_next.sda_oe = 1'b0;
            ctrl_next.state = rsc_pkg::ST_CMD;
          end
        end
        rsc_pkg::ST_ACK_C: begin
          ctrl_next.sda_oe = 1'b0;
          ctrl_next.state = rsc_pkg::ST_WDATA;
        end
        rsc_pkg::ST_ACK_W: begin
          ctrl_next.sda_oe = 1'b0;
          ctrl_next.state = rsc_pkg::ST_CMD;
        end
        rsc_pkg::ST_RDATA: begin
          if (ctrl_reg.cnt == 3'h0) begin
            ctrl_next.sda_oe = 1'b0;
            ctrl_next.state = rsc_pkg::ST_RACK;
          end else begin
            ctrl_next.sda_oe = ~ctrl_reg.rd_byte[3'h7 - ctrl_reg.cnt];
            ctrl_next.cnt = ctrl_reg.cnt + 3'h1;
          end
        end
        default: begin
        end
      endcase
    end

    // Hold reset on rail low or pushbutton
    if (~ctrl_reg.aon_s2 | ctrl_reg.pb_s2) begin
      ctrl_next.rst_n = 1'b0;
      ctrl_next.rst_cnt = 25'h0;
      if (ctrl_reg.pb_s2) begin
        ctrl_next.rst_long = 1'b1;
      end
    end else if (~ctrl_reg.rst_n) begin
      ctrl_next.rst_cnt = ctrl_reg.rst_cnt + 25'h1;
      if (ctrl_reg.rst_cnt >= (ctrl_reg.rst_long ? 25'(P_RST_PB_CYC - 1) : 25'(P_RST_MIN_CYC - 1))) begin
        ctrl_next.rst_n = 1'b1;
        ctrl_next.rst_long = 1'b0;
      end
    end

    // Register or pin enable, keep-alive in hibernate
    ctrl_next.rail_en = ctrl_reg.hib_s2 ? (want_en & ka_rail) : want_en;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_reg <= '0;
      ctrl_reg.scl_s1 <= 1'b1;
      ctrl_reg.scl_s2 <= 1'b1;
      ctrl_reg.scl_q <= 1'b1;
      ctrl_reg.sda_s1 <= 1'b1;
      ctrl_reg.sda_s2 <= 1'b1;
      ctrl_reg.sda_q <= 1'b1;
      ctrl_reg.state <= rsc_pkg::ST_IDLE;
      ctrl_reg.output_enable_reg <= rsc_pkg::OUT_EN_RESET;
      ctrl_reg.sel <= rsc_pkg::VCHG_RESET[3:0];
      ctrl_reg.spare <= rsc_pkg::SPARE_RESET;
      ctrl_reg.dac <= {4{rsc_pkg::CODE_RESET}};
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign o_sda_o = 1'b0;
  assign o_sda_oe = ctrl_reg.sda_oe;
  assign o_reset_out_n = ctrl_reg.rst_n;
  assign o_rail_en = ctrl_reg.rail_en;
  assign o_dac_code = ctrl_reg.dac;
endmodule

// ===== rsc_regulator_ctrl_monitor.sv
// Purpose: Port checker of the set-point control block
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to the top module at the foot of this file
`timescale 1ns/1ps
module rsc_regulator_ctrl_monitor #(
  parameter int P_RST_MIN_CYC = rsc_pkg::RST_MIN_CYC,
  parameter int P_RST_PB_CYC = rsc_pkg::RST_PB_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Pins
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  input wire logic i_standby_select_pin,
  input wire logic [3:0] i_step_en_pins,
  input wire logic [1:0] i_linear_enable_pins,
  input wire logic i_hibernate,
  input wire logic i_always_on_rail,
  input wire logic i_pb_hard_reset,
  // Outputs
  input wire logic o_reset_out_n,
  input wire logic [5:0] o_rail_en,
  input wire logic [19:0] o_dac_code
);
  int low_cnt_reg;
  logic pb_seen_reg;
  logic [19:0] dac_prev_reg;
  logic step_ok;
  logic [5:0] pins;
  logic [5:0] a;
  logic [5:0] b;
  assign pins = {i_linear_enable_pins, i_step_en_pins};
  // Cycles held low with both sources good
  always_ff @(posedge i_clk) begin
    dac_prev_reg <= o_dac_code;
    low_cnt_reg <= (i_sys_rst || o_reset_out_n || !i_always_on_rail || i_pb_hard_reset) ? 0 : low_cnt_reg + 1;
    // Pushbutton cause kept until release
    pb_seen_reg <= !i_sys_rst && (i_pb_hard_reset || (pb_seen_reg && !o_reset_out_n));
  end
  // Each rail moves at most one code
  always_comb begin
    step_ok = 1'b1;
    a = 6'h00;
    b = 6'h00;
    for (int r = 0; r < 4; r++) begin
      a = {1'b0, o_dac_code[5*r +: 5]};
      b = {1'b0, dac_prev_reg[5*r +: 5]};
      if (a > b + 6'h01 || b > a + 6'h01) begin
        step_ok = 1'b0;
      end
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  AST_RESET_STATE: assert property ($fell(i_sys_rst) |-> o_dac_code == {4{rsc_pkg::CODE_RESET}} && o_rail_en == 6'h00)
    else $error("Outputs not at reset state");
  AST_RAIL_LOSS: assert property (!i_always_on_rail |-> ##[1:6] !o_reset_out_n)
    else $error("Reset output not low on rail loss");
  AST_PB_RESET: assert property (i_pb_hard_reset |-> ##[1:6] !o_reset_out_n)
    else $error("Reset output not low on pushbutton");
  AST_RELEASE_MIN: assert property ($rose(o_reset_out_n) |-> low_cnt_reg >= P_RST_MIN_CYC)
    else $error("Reset output released too early");
  AST_RELEASE_PB: assert property ($rose(o_reset_out_n) && pb_seen_reg |-> low_cnt_reg >= P_RST_PB_CYC)
    else $error("Reset output released early after pushbutton");
  AST_RELEASE_MAX: assert property (low_cnt_reg <= P_RST_PB_CYC + 10)
    else $error("Reset output held too long");
  AST_PIN_ENABLE: assert property ((!i_hibernate && $stable(pins))[*5] |-> (pins & ~o_rail_en) == 6'h00)
    else $error("Enable pin did not turn rail on");
  AST_HIBERNATE_OFF: assert property (i_hibernate[*5] |-> !o_rail_en[3] && !o_rail_en[5])
    else $error("Rail without keep-alive on in hibernate");
  AST_DAC_STEP: assert property (step_ok)
    else $error("Reference code jumped");
  AST_DAC_SPACING: assert property ($changed(o_dac_code) |=> $stable(o_dac_code) [*8])
    else $error("Reference code stepped too fast");
  AST_ACK_TIMING: assert property ($changed(o_sda_oe) |-> !i_scl && !$past(i_scl))
    else $error("Data pin moved while serial clock high");
  COV_RELEASE: cover property ($rose(o_reset_out_n));
  COV_SLEW: cover property ($changed(o_dac_code));
  COV_ACK: cover property ($rose(o_sda_oe));
endmodule

bind rsc_regulator_ctrl rsc_regulator_ctrl_monitor #(.P_RST_MIN_CYC(P_RST_MIN_CYC), .P_RST_PB_CYC(P_RST_PB_CYC))
  rsc_regulator_ctrl_monitor_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_standby_select_pin(i_standby_select_pin),
  .i_step_en_pins(i_step_en_pins), .i_linear_enable_pins(i_linear_enable_pins), .i_hibernate(i_hibernate),
  .i_always_on_rail(i_always_on_rail), .i_pb_hard_reset(i_pb_hard_reset), .o_reset_out_n(o_reset_out_n),
  .o_rail_en(o_rail_en), .o_dac_code(o_dac_code));

// ===== rsc_i2c_master_model.sv
// Purpose: Processor-side serial master on the control port
// Assumes: Open-drain data line with pull-up, 10 clk per clock phase
// Notes: Bench calls the transfer tasks
`timescale 1ns/1ps
module rsc_i2c_master_model (
  // Clock
  input wire logic i_clk,
  // Serial pins
  input wire logic i_sda_line,
  output logic o_scl,
  output logic o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic half();
    repeat (10) @(posedge i_clk);
  endtask
  task automatic start();
    o_sda_low <= 1'b0;
    half();
    o_scl <= 1'b1;
    half();
    o_sda_low <= 1'b1;
    half();
    o_scl <= 1'b0;
  endtask
  task automatic stop();
    o_sda_low <= 1'b1;
    half();
    o_scl <= 1'b1;
    half();
    o_sda_low <= 1'b0;
    half();
  endtask
  // Data set while clock low, sampled at end of high phase
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      o_sda_low <= (i == 0) ? 1'b0 : !tx[i-1];
      half();
      o_scl <= 1'b1;
      half();
      if (i > 0) begin
        rx[i-1] = i_sda_line;
      end
      ack = !i_sda_line;
      o_scl <= 1'b0;
    end
  endtask
  task automatic write_reg(input logic [7:0] adr, input logic [7:0] cmd, input logic [7:0] dat, output logic ok);
    logic [7:0] rx;
    logic a0;
    logic a1;
    logic a2;
    start();
    xfer(adr, rx, a0);
    xfer(cmd, rx, a1);
    xfer(dat, rx, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic read_reg(input logic [7:0] cmd, output logic [7:0] dat, output logic ok);
    logic [7:0] rx;
    logic a0;
    logic a1;
    logic a2;
    logic nack;
    start();
    xfer(8'h68, rx, a0);
    xfer(cmd, rx, a1);
    start();
    xfer(8'h69, rx, a2);
    xfer(8'hFF, dat, nack);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule

// ===== rsc_regulator_ctrl_tb_top.sv
// Purpose: Self-checking bench of the set-point control block
// Assumes: Short reset release counts of 20 and 50 clk
// Notes: Registers reached only over the serial port
`timescale 1ns/1ps
module rsc_regulator_ctrl_tb_top;
  localparam int MIN_CYC = 20;
  localparam int PB_CYC = 50;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic stby = 1'b0;
  logic [3:0] step_pins = 4'h0;
  logic [1:0] lin_pins = 2'h0;
  logic hib = 1'b0;
  logic rail_ok = 1'b0;
  logic pb = 1'b0;
  logic scl;
  logic sda_low;
  logic sda_o;
  logic sda_oe;
  logic rst_out_n;
  logic [5:0] rail_en;
  logic [19:0] dac;
  wire logic sda_line = (sda_oe ? sda_o : 1'b1) & !sda_low;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  rsc_regulator_ctrl #(.P_RST_MIN_CYC(MIN_CYC), .P_RST_PB_CYC(PB_CYC)) rsc_regulator_ctrl_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_scl(scl), .i_sda(sda_line), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
    .i_standby_select_pin(stby), .i_step_en_pins(step_pins), .i_linear_enable_pins(lin_pins),
    .i_hibernate(hib), .i_always_on_rail(rail_ok), .i_pb_hard_reset(pb), .o_reset_out_n(rst_out_n),
    .o_rail_en(rail_en), .o_dac_code(dac));
  rsc_i2c_master_model rsc_i2c_master_model_i (.i_clk(i_clk), .i_sda_line(sda_line), .o_scl(scl),
    .o_sda_low(sda_low));
  always #25 i_clk = ~i_clk;
  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] dat);
    logic ok;
    rsc_i2c_master_model_i.write_reg(8'h68, cmd, dat, ok);
    check("write ack", ok, 1'b1);
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    rsc_i2c_master_model_i.read_reg(cmd, d, ok);
    check("read ack", ok, 1'b1);
    check("read data", d, exp);
  endtask
  // Cycles from cause removal to release, bounded
  task automatic release_in(input int lo);
    int n;
    n = 0;
    while (rst_out_n !== 1'b1 && n < 500) begin
      @(posedge i_clk);
      n++;
    end
    check("release delay", n >= lo && n <= lo + 10, 1'b1);
  endtask
  initial begin
    logic ok;
    cyc(16);
    i_sys_rst <= 1'b0;
    cyc(2);
    check("dac reset", dac, {4{rsc_pkg::CODE_RESET}});
    check("data pin level", sda_o, 1'b0);
    cyc(30);
    check("reset out", rst_out_n, 1'b0);
    rail_ok <= 1'b1;
    release_in(MIN_CYC);
    rd(8'h23, 8'h19);
    rd(8'h33, 8'h19);
    rd(8'h7F, 8'h00);
    wr(8'h14, 8'hA5);
    rd(8'h14, 8'hA5);
    rsc_i2c_master_model_i.write_reg(8'h6A, 8'h14, 8'h3C, ok);
    check("foreign address ack", ok, 1'b0);
    wr(8'h10, 8'h05);
    cyc(5);
    check("register enables", rail_en, 6'h05);
    rd(8'h10, 8'h05);
    stby <= 1'b1;
    cyc(100);
    check("equal set points", dac, {4{5'h19}});
    stby <= 1'b0;
    wr(8'h24, 8'h95);
    stby <= 1'b1;
    cyc(30);
    check("slew midway", dac[4:0] < 5'h19 && dac[4:0] > 5'h15, 1'b1);
    cyc(100);
    check("standby set point", dac, {{3{5'h19}}, 5'h15});
    stby <= 1'b0;
    cyc(130);
    check("run set point", dac, {4{5'h19}});
    wr(8'h26, 8'h1F);
    wr(8'h20, 8'h04);
    cyc(150);
    check("go slew", dac, {{2{5'h19}}, 5'h1F, 5'h19});
    rd(8'h20, 8'h00);
    wr(8'h20, 8'h03);
    cyc(150);
    check("select slew", dac, {5'h19, 5'h19, 5'h1F, 5'h15});
    rd(8'h20, 8'h02);
    hib <= 1'b1;
    cyc(6);
    check("keep-alive", rail_en, 6'h01);
    hib <= 1'b0;
    wr(8'h10, 8'h00);
    step_pins <= 4'hF;
    lin_pins <= 2'h3;
    cyc(6);
    check("enable pins", rail_en, 6'h3F);
    rail_ok <= 1'b0;
    cyc(8);
    check("rail loss", rst_out_n, 1'b0);
    rail_ok <= 1'b1;
    release_in(MIN_CYC);
    pb <= 1'b1;
    cyc(8);
    check("pushbutton", rst_out_n, 1'b0);
    pb <= 1'b0;
    release_in(PB_CYC);
    wrap_up();
  end
endmodule
